//--- design/twbc_pkg.sv
// package: register map, fields, rate table and mode codes of the bus control
package twbc_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TWBC_OFF_CTRL = 8'h00;
    localparam logic [7:0] TWBC_OFF_RATE = 8'h04;
    localparam logic [7:0] TWBC_OFF_STAT = 8'h08;
    localparam logic [7:0] TWBC_OFF_MASK = 8'h0C;
    localparam logic [7:0] TWBC_OFF_STATE = 8'h10;

    // ------------------------------------------------------------------
    // bus_control_reg fields
    // ------------------------------------------------------------------
    localparam int TWBC_ON_BIT = 7;
    localparam int TWBC_GATE_BIT = 6;
    localparam int TWBC_CS_BIT = 5;
    localparam int TWBC_DIR_BIT = 4;

    // ------------------------------------------------------------------
    // rate register fields
    // ------------------------------------------------------------------
    localparam int TWBC_RANGE_BIT = 3;
    localparam int TWBC_SEL_HI = 2;
    localparam int TWBC_SEL_LO = 0;

    // ------------------------------------------------------------------
    // event bits of status and mask
    // ------------------------------------------------------------------
    localparam int TWBC_EV_ARB = 0;
    localparam int TWBC_EV_ADDR = 1;
    localparam int TWBC_EV_DONE = 2;
    localparam int TWBC_EV_NUM = 3;

    // ------------------------------------------------------------------
    // state register fields
    // ------------------------------------------------------------------
    localparam int TWBC_ST_PEND_V = 0;
    localparam int TWBC_ST_PEND_DIR = 1;
    localparam int TWBC_ST_LOST = 2;
    localparam int TWBC_ST_SCL = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] TWBC_SEL_RST = 3'h0;
    localparam logic TWBC_RANGE_RST = 1'b0;
    localparam logic [TWBC_EV_NUM-1:0] TWBC_MASK_RST = 3'h0;

    // ------------------------------------------------------------------
    // system clock divisors, indexed by rate select
    // ------------------------------------------------------------------
    localparam logic [8:0] TWBC_DIV_R0 [0:7] = '{
        9'h01C, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080
    };
    localparam logic [8:0] TWBC_DIV_R1 [0:7] = '{
        9'h038, 9'h050, 9'h060, 9'h080, 9'h0A0, 9'h0C8, 9'h0E0, 9'h100
    };

    // ------------------------------------------------------------------
    // operating modes, {controller_select, direction_select}
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TWBC_SLV_RX = 2'h0,
        TWBC_SLV_TX = 2'h1,
        TWBC_MST_TX = 2'h3,
        TWBC_MST_RX = 2'h2
    } twbc_mode_e;

    localparam logic [1:0] TWBC_HTRANS_NONSEQ = 2'h2;

endpackage : twbc_pkg

//--- design/twbc_sub.sv
// modules: two-flop synchroniser and master transfer clock divider
`timescale 1ns/100ps

module twbc_sync2 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic meta;
        logic stable;
    } twbc_sync_s;

    twbc_sync_s q;
    twbc_sync_s d;

    always_comb begin
        d.meta = async_i;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stable;
endmodule : twbc_sync2

module twbc_rate_div (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic range_i,
    input wire logic [2:0] sel_i,
    output logic scl_o,
    output logic period_o
);
    typedef struct packed {
        logic scl;
        logic [7:0] cnt;
        logic period;
    } twbc_div_s;

    twbc_div_s q;
    twbc_div_s d;
    logic [8:0] div;
    logic [7:0] half;

    always_comb begin
        div = range_i ? twbc_pkg::TWBC_DIV_R1[sel_i]
                      : twbc_pkg::TWBC_DIV_R0[sel_i];
        half = div[8:1];
        d = q;
        d.period = 1'b0;
        if (!run_i) begin
            d.cnt = 8'h00;
            d.scl = 1'b1;
        end else if (q.cnt == 8'(half - 8'h01)) begin
            d.cnt = 8'h00;
            d.scl = ~q.scl;
            d.period = ~q.scl;
        end else begin
            d.cnt = 8'(q.cnt + 8'h01);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{scl: 1'b1, cnt: 8'h00, period: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign scl_o = q.scl;
    assign period_o = q.period;

    default clocking twbc_div_cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_DIV_RESTART: assert property (
        !run_i |=> q.cnt == 8'h00 && q.scl
    ) else $error("divider not restarted while stopped");

    AST_DIV_HALF: assert property (
        run_i && $past(run_i) && $changed(q.scl)
            |-> $past(q.cnt) == 8'(half - 8'h01)
    ) else $error("clock edge not at half divisor");
endmodule : twbc_rate_div

//--- design/twbc_top.sv
// top: bus control register, rate select and mode control behind AHB-Lite
`timescale 1ns/100ps

module twbc_top (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic BUS_FORMAT_I,
    input wire logic ARB_LOST_I,
    input wire logic ADDR_MATCH_I,
    input wire logic RW_BIT_I,
    input wire logic XFER_BUSY_I,
    input wire logic XFER_DONE_I,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_O,
    output logic SCL_PERIOD_O,
    output logic PINS_BUS_O,
    output logic ENGINE_INIT_O,
    output logic OWN_ADDR_ACCESS_O,
    output logic MODE_DATA_ACCESS_O,
    output logic [1:0] MODE_O,
    output logic IRQ_O
);
    localparam int EVN = twbc_pkg::TWBC_EV_NUM;

    typedef struct packed {
        logic on;
        logic gate;
        twbc_pkg::twbc_mode_e mode;
        logic range;
        logic [2:0] sel;
        logic [EVN-1:0] stat;
        logic [EVN-1:0] mask;
        logic pend_v;
        logic pend_dir;
        logic lost;
        logic read_zero;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
    } twbc_top_s;

    twbc_top_s q;
    twbc_top_s d;

    logic take;
    logic wr_ctrl;
    logic cs_n;
    logic dir_n;
    logic [EVN-1:0] ev;
    logic [EVN-1:0] clr;
    logic hw_arb;
    logic hw_addr;
    logic div_run;
    logic scl_lvl;
    logic scl_sync;
    logic [7:0] addr;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    function automatic logic [31:0] twbc_read(input twbc_top_s s,
                                              input logic [7:0] a,
                                              input logic line);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            twbc_pkg::TWBC_OFF_CTRL: begin
                r[twbc_pkg::TWBC_ON_BIT] = s.on;
                r[twbc_pkg::TWBC_GATE_BIT] = s.gate;
                r[twbc_pkg::TWBC_CS_BIT] = s.mode[1];
                r[twbc_pkg::TWBC_DIR_BIT] = s.mode[0];
            end
            twbc_pkg::TWBC_OFF_RATE: begin
                r[twbc_pkg::TWBC_RANGE_BIT] = s.range;
                r[twbc_pkg::TWBC_SEL_HI:twbc_pkg::TWBC_SEL_LO] = s.sel;
            end
            twbc_pkg::TWBC_OFF_STAT: begin
                r[EVN-1:0] = s.stat;
            end
            twbc_pkg::TWBC_OFF_MASK: begin
                r[EVN-1:0] = s.mask;
            end
            twbc_pkg::TWBC_OFF_STATE: begin
                r[twbc_pkg::TWBC_ST_PEND_V] = s.pend_v;
                r[twbc_pkg::TWBC_ST_PEND_DIR] = s.pend_dir;
                r[twbc_pkg::TWBC_ST_LOST] = s.lost;
                r[twbc_pkg::TWBC_ST_SCL] = line;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction : twbc_read

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        addr = HADDR_I[7:0];
        take = HSEL_I && HTRANS_I == twbc_pkg::TWBC_HTRANS_NONSEQ && HREADY_I;
        wr_ctrl = q.dph_wr && q.dph_addr == twbc_pkg::TWBC_OFF_CTRL;
        cs_n = q.mode[1];
        dir_n = q.mode[0];
        ev = '0;
        clr = '0;
        hw_arb = q.on && BUS_FORMAT_I && ARB_LOST_I && q.mode[1];
        hw_addr = q.on && BUS_FORMAT_I && ADDR_MATCH_I
            && q.mode == twbc_pkg::TWBC_SLV_RX;

        // address phase: latch write target, sample read data
        d.dph_wr = take && HWRITE_I;
        d.dph_addr = addr;
        if (take && !HWRITE_I) begin
            d.rdata = twbc_read(q, addr, scl_sync);
            if (addr == twbc_pkg::TWBC_OFF_CTRL && q.lost && !q.mode[1]) begin
                d.read_zero = 1'b1;
            end
        end

        // data phase writes
        if (wr_ctrl) begin
            d.on = HWDATA_I[twbc_pkg::TWBC_ON_BIT];
            d.gate = HWDATA_I[twbc_pkg::TWBC_GATE_BIT];
            if (!HWDATA_I[twbc_pkg::TWBC_CS_BIT]) begin
                cs_n = 1'b0;
            end else if (!q.lost || q.read_zero) begin
                cs_n = 1'b1;
                d.lost = 1'b0;
                d.read_zero = 1'b0;
            end
            if (XFER_BUSY_I) begin
                d.pend_v = 1'b1;
                d.pend_dir = HWDATA_I[twbc_pkg::TWBC_DIR_BIT];
            end else begin
                dir_n = HWDATA_I[twbc_pkg::TWBC_DIR_BIT];
                d.pend_v = 1'b0;
            end
        end
        if (q.dph_wr && q.dph_addr == twbc_pkg::TWBC_OFF_RATE) begin
            d.range = HWDATA_I[twbc_pkg::TWBC_RANGE_BIT];
            d.sel = HWDATA_I[twbc_pkg::TWBC_SEL_HI:twbc_pkg::TWBC_SEL_LO];
        end
        if (q.dph_wr && q.dph_addr == twbc_pkg::TWBC_OFF_MASK) begin
            d.mask = HWDATA_I[EVN-1:0];
        end
        if (q.dph_wr && q.dph_addr == twbc_pkg::TWBC_OFF_STAT) begin
            clr = HWDATA_I[EVN-1:0];
        end

        // deferred direction change at end of transfer
        if (q.pend_v && XFER_DONE_I) begin
            dir_n = q.pend_dir;
            d.pend_v = 1'b0;
        end
        if (q.on && XFER_DONE_I) begin
            ev[twbc_pkg::TWBC_EV_DONE] = 1'b1;
        end

        // slave addressed: R/W bit picks direction
        if (hw_addr) begin
            dir_n = RW_BIT_I;
            ev[twbc_pkg::TWBC_EV_ADDR] = 1'b1;
        end

        // arbitration lost: drop to slave receive
        if (hw_arb) begin
            cs_n = 1'b0;
            dir_n = 1'b0;
            d.pend_v = 1'b0;
            d.lost = 1'b1;
            d.read_zero = 1'b0;
            ev[twbc_pkg::TWBC_EV_ARB] = 1'b1;
        end

        // interface off: pending direction change cleared
        if (!q.on) begin
            d.pend_v = 1'b0;
        end

        d.mode = twbc_pkg::twbc_mode_e'({cs_n, dir_n});
        // set wins over write-one-to-clear
        d.stat = (q.stat & ~clr) | ev;
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q <= '{
                on: 1'b0,
                gate: 1'b0,
                mode: twbc_pkg::TWBC_SLV_RX,
                range: twbc_pkg::TWBC_RANGE_RST,
                sel: twbc_pkg::TWBC_SEL_RST,
                stat: '0,
                mask: twbc_pkg::TWBC_MASK_RST,
                pend_v: 1'b0,
                pend_dir: 1'b0,
                lost: 1'b0,
                read_zero: 1'b0,
                dph_wr: 1'b0,
                dph_addr: 8'h00,
                rdata: 32'h0000_0000
            };
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // bus line and clock generation
    // ------------------------------------------------------------------
    assign div_run = q.on && q.mode[1];

    twbc_sync2 u_scl_sync (
        .clk_i(MCLK_I),
        .rst_n_i(NRST_I),
        .async_i(SCL_I),
        .sync_o(scl_sync)
    );

    twbc_rate_div u_rate_div (
        .clk_i(MCLK_I),
        .rst_n_i(NRST_I),
        .run_i(div_run),
        .range_i(q.range),
        .sel_i(q.sel),
        .scl_o(scl_lvl),
        .period_o(SCL_PERIOD_O)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign SCL_O = 1'b0;
    assign SCL_OE_O = div_run && !scl_lvl;
    assign PINS_BUS_O = q.on;
    assign MODE_DATA_ACCESS_O = q.on;
    assign ENGINE_INIT_O = !q.on;
    assign OWN_ADDR_ACCESS_O = !q.on;
    assign MODE_O = q.mode;
    assign IRQ_O = q.gate && |(q.stat & q.mask);
    assign HRDATA_O = q.rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking twbc_top_cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);

    sequence twbc_busy_dir_write;
        q.on && wr_ctrl && XFER_BUSY_I && !XFER_DONE_I
            && !hw_arb && !hw_addr
            && HWDATA_I[twbc_pkg::TWBC_DIR_BIT] != q.mode[0];
    endsequence

    // held direction meets transfer end, nothing else competing
    sequence twbc_quiet_until_done;
        q.pend_v && XFER_DONE_I && !wr_ctrl && !hw_arb && !hw_addr;
    endsequence

    AST_DIR_DEFER: assert property (
        twbc_busy_dir_write |=> q.pend_v && q.mode[0] == $past(q.mode[0])
    ) else $error("direction changed during a transfer");

    AST_DIR_APPLY: assert property (
        twbc_quiet_until_done
            |=> !q.pend_v && q.mode[0] == $past(q.pend_dir)
    ) else $error("pending direction not applied at transfer end");

    AST_ARB_DROP: assert property (
        hw_arb |=> q.mode == twbc_pkg::TWBC_SLV_RX && q.lost
            && q.stat[twbc_pkg::TWBC_EV_ARB]
    ) else $error("arbitration loss did not drop to slave receive");

    AST_ADDR_DIR: assert property (
        hw_addr && !hw_arb && !wr_ctrl
            |=> q.mode[0] == $past(RW_BIT_I) && !q.mode[1]
    ) else $error("direction not taken from first frame");

    AST_REARM_BLOCK: assert property (
        q.lost && !q.read_zero && wr_ctrl
            && HWDATA_I[twbc_pkg::TWBC_CS_BIT] |=> !q.mode[1]
    ) else $error("select set without reading zero first");

    AST_REARM_OK: assert property (
        q.lost && q.read_zero && wr_ctrl && !hw_arb
            && HWDATA_I[twbc_pkg::TWBC_CS_BIT] |=> q.mode[1] && !q.lost
    ) else $error("select not set after reading zero");

    AST_IRQ_GATE: assert property (
        $rose(q.stat[twbc_pkg::TWBC_EV_ARB])
            && q.mask[twbc_pkg::TWBC_EV_ARB]
            |-> IRQ_O == q.gate
    ) else $error("interrupt not gated by irq_gate");

    AST_OFF_IDLE: assert property (
        !q.on && !wr_ctrl |=> !q.pend_v && !SCL_OE_O && OWN_ADDR_ACCESS_O
    ) else $error("interface off but state not idle");

    AST_ON_PINS: assert property (
        $rose(q.on) |-> PINS_BUS_O && MODE_DATA_ACCESS_O && !ENGINE_INIT_O
    ) else $error("interface on but pins not bus lines");

    AST_SLAVE_NO_CLK: assert property (
        !q.mode[1] |-> !SCL_OE_O ##1 (q.mode[1] || !SCL_OE_O)
    ) else $error("clock driven in slave mode");

    AST_MODE_MAP: assert property (
        q.on && q.mode == twbc_pkg::TWBC_MST_TX |-> div_run
    ) else $error("master mode without clock generation");

endmodule : twbc_top

//--- sim/twbc_peer_model.sv
// peer model: engine events and the shared bus clock line
`timescale 1ns/100ps

module twbc_peer_model (
    input wire logic clk_i,
    input wire logic scl_oe_i,
    output logic bus_format_o,
    output logic arb_lost_o,
    output logic addr_match_o,
    output logic rw_bit_o,
    output logic xfer_busy_o,
    output logic xfer_done_o,
    output logic scl_o
);
    // --------------------
    // line and events
    // --------------------
    // pulled-up line, low only while the device drives it
    assign scl_o = scl_oe_i ? 1'b0 : 1'b1;

    initial begin
        bus_format_o = 1'b1;
        arb_lost_o = 1'b0;
        addr_match_o = 1'b0;
        rw_bit_o = 1'b1;
        xfer_busy_o = 1'b0;
        xfer_done_o = 1'b0;
    end

    task automatic set_format(input logic f);
        bus_format_o <= f;
    endtask : set_format

    task automatic lose_arb();
        arb_lost_o <= 1'b1;
        @(posedge clk_i);
        arb_lost_o <= 1'b0;
    endtask : lose_arb

    task automatic match(input logic rw);
        addr_match_o <= 1'b1;
        rw_bit_o <= rw;
        @(posedge clk_i);
        addr_match_o <= 1'b0;
        // not valid outside the frame: show the inverse
        rw_bit_o <= ~rw;
    endtask : match

    task automatic xfer_begin();
        xfer_busy_o <= 1'b1;
    endtask : xfer_begin

    task automatic xfer_end();
        xfer_done_o <= 1'b1;
        xfer_busy_o <= 1'b0;
        @(posedge clk_i);
        xfer_done_o <= 1'b0;
    endtask : xfer_end
endmodule : twbc_peer_model

//--- sim/twowire_bus_ctrl_rate_tb_top.sv
// testbench: bus control, modes, events and rate divider
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %s expected %0h seen %0h", nm, e, g); \
    end end

module twowire_bus_ctrl_rate_tb_top;
    // --------------------
    // signals
    // --------------------
    localparam logic [7:0] A_CTRL = twbc_pkg::TWBC_OFF_CTRL;
    localparam logic [7:0] A_RATE = twbc_pkg::TWBC_OFF_RATE;
    localparam logic [7:0] A_STAT = twbc_pkg::TWBC_OFF_STAT;
    localparam logic [7:0] A_MASK = twbc_pkg::TWBC_OFF_MASK;
    localparam logic [7:0] A_STATE = twbc_pkg::TWBC_OFF_STATE;
    typedef struct {
        logic [7:0] wd;
        logic [1:0] mode;
        logic on;
    } twbc_row_s;
    twbc_row_s rows [0:6] = '{'{8'h00, 2'h0, 1'b0}, '{8'h80, 2'h0, 1'b1},
        '{8'h90, 2'h1, 1'b1}, '{8'hA0, 2'h2, 1'b1}, '{8'hB0, 2'h3, 1'b1},
        '{8'hC0, 2'h0, 1'b1}, '{8'h30, 2'h3, 1'b0}};
    int divs [0:15] = '{28, 40, 48, 64, 80, 100, 112, 128,
        56, 80, 96, 128, 160, 200, 224, 256};
    logic mclk, nrst, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans, mode;
    logic hready, hresp, scl_o, scl_oe, scl_per, pins, einit;
    logic own_acc, md_acc, irq, bfmt, arb, amatch, rwb, busy, done, line;
    int n_mismatch = 0;
    int checks_done = 0;
    int per, low;

    twbc_top i_dut (.MCLK_I(mclk), .NRST_I(nrst), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .BUS_FORMAT_I(bfmt), .ARB_LOST_I(arb), .ADDR_MATCH_I(amatch),
        .RW_BIT_I(rwb), .XFER_BUSY_I(busy), .XFER_DONE_I(done),
        .SCL_I(line), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
        .SCL_PERIOD_O(scl_per), .PINS_BUS_O(pins), .ENGINE_INIT_O(einit),
        .OWN_ADDR_ACCESS_O(own_acc), .MODE_DATA_ACCESS_O(md_acc),
        .MODE_O(mode), .IRQ_O(irq));

    twbc_peer_model i_peer (.clk_i(mclk), .scl_oe_i(scl_oe),
        .bus_format_o(bfmt), .arb_lost_o(arb), .addr_match_o(amatch),
        .rw_bit_o(rwb), .xfer_busy_o(busy), .xfer_done_o(done),
        .scl_o(line));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // --------------------
    // tasks
    // --------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= twbc_pkg::TWBC_HTRANS_NONSEQ;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rdata = hrdata;
    endtask : bus

    task automatic chk_state(input logic [1:0] m, input logic on);
        @(negedge mclk);
        `CHK("mode", m, mode)
        `CHK("pins", on, pins)
        `CHK("init", ~on, einit)
        `CHK("own_acc", ~on, own_acc)
        `CHK("md_acc", on, md_acc)
    endtask : chk_state

    task automatic measure();
        int n;
        n = 0;
        per = 0;
        low = 0;
        @(negedge mclk);
        while (scl_per !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        do begin
            if (scl_oe === 1'b1) low++;
            per++;
            @(negedge mclk);
        end while (scl_per !== 1'b1 && per < 600);
    endtask : measure

    task automatic quiet(input string nm);
        int seen;
        seen = 0;
        repeat (300) begin
            @(negedge mclk);
            if (scl_per !== 1'b0 || scl_oe !== 1'b0) seen++;
        end
        `CHK(nm, 0, seen)
    endtask : quiet

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end

    // --------------------
    // sequence
    // --------------------
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        chk_state(2'h0, 1'b0);
        `CHK("irq", 1'b0, irq)
        `CHK("scl_o", 1'b0, scl_o)
        @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, A_CTRL, {24'h000000, rows[i].wd});
            bus(1'b0, A_CTRL, 32'h00000000);
            `CHK("ctrl", {24'h000000, rows[i].wd}, rdata)
            chk_state(rows[i].mode, rows[i].on);
            @(posedge mclk);
        end
        bus(1'b0, 8'h20, 32'h00000000);
        `CHK("unmapped", 32'h00000000, rdata)
        `CHK("resp", 1'b0, hresp)
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, A_CTRL, 32'h00000020);
            bus(1'b1, A_RATE, c);
            bus(1'b1, A_CTRL, 32'h000000A0);
            measure();
            `CHK("period", divs[c], per)
            `CHK("low", divs[c] / 2, low)
            @(posedge mclk);
        end
        bus(1'b1, A_CTRL, 32'h00000020);
        quiet("off");
        @(posedge mclk);
        bus(1'b1, A_CTRL, 32'h00000080);
        quiet("slave");
        @(posedge mclk);
        bus(1'b1, A_MASK, 32'h00000001);
        bus(1'b1, A_CTRL, 32'h000000E0);
        i_peer.lose_arb();
        chk_state(2'h0, 1'b1);
        `CHK("irq_on", 1'b1, irq)
        @(posedge mclk);
        bus(1'b0, A_STAT, 32'h00000000);
        `CHK("stat", 1'b1, rdata[0])
        bus(1'b1, A_CTRL, 32'h00000080);
        chk_state(2'h0, 1'b1);
        `CHK("irq_gated", 1'b0, irq)
        @(posedge mclk);
        bus(1'b1, A_CTRL, 32'h000000C0);
        bus(1'b1, A_MASK, 32'h00000000);
        @(negedge mclk);
        `CHK("irq_mask", 1'b0, irq)
        @(posedge mclk);
        bus(1'b1, A_MASK, 32'h00000001);
        bus(1'b1, A_STAT, 32'h00000001);
        @(negedge mclk);
        `CHK("irq_clr", 1'b0, irq)
        @(posedge mclk);
        bus(1'b1, A_CTRL, 32'h000000E0);
        chk_state(2'h0, 1'b1);
        @(posedge mclk);
        bus(1'b0, A_CTRL, 32'h00000000);
        `CHK("cs_read", 1'b0, rdata[5])
        bus(1'b1, A_CTRL, 32'h000000E0);
        chk_state(2'h2, 1'b1);
        @(posedge mclk);
        i_peer.set_format(1'b0);
        i_peer.lose_arb();
        chk_state(2'h2, 1'b1);
        @(posedge mclk);
        i_peer.set_format(1'b1);
        bus(1'b1, A_CTRL, 32'h00000080);
        i_peer.match(1'b1);
        chk_state(2'h1, 1'b1);
        @(posedge mclk);
        bus(1'b1, A_CTRL, 32'h00000080);
        i_peer.match(1'b0);
        chk_state(2'h0, 1'b1);
        @(posedge mclk);
        i_peer.xfer_begin();
        bus(1'b1, A_CTRL, 32'h00000090);
        chk_state(2'h0, 1'b1);
        @(posedge mclk);
        bus(1'b0, A_STATE, 32'h00000000);
        `CHK("pend", 2'h3, rdata[1:0])
        `CHK("line", 1'b1, rdata[3])
        i_peer.xfer_end();
        chk_state(2'h1, 1'b1);
        @(posedge mclk);
        // address match and transfer end both leave a status bit
        bus(1'b0, A_STAT, 32'h00000000);
        `CHK("stat_ev", 32'h00000006, rdata)
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_state(2'h0, 1'b0);
        @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        bus(1'b0, A_CTRL, 32'h00000000);
        `CHK("ctrl_rst", 32'h00000000, rdata)
        complete_run();
    end
endmodule : twowire_bus_ctrl_rate_tb_top
